// [hw/pmmc_pkg.sv]
package pmmc_pkg;
    // special-register numbers
    localparam logic [9:0] PMMC_SPR_CONTROL = 10'h3b8;
    localparam logic [9:0] PMMC_SPR_MIRROR = 10'h3a8;
    localparam logic [31:0] PMMC_RESET = 32'h0000_0000;
    // little-endian positions of big-endian bits (bit n -> 31-n)
    localparam int PMMC_B_FREEZE = 31;
    localparam int PMMC_B_FRZ_SUP = 30;
    localparam int PMMC_B_FRZ_USR = 29;
    localparam int PMMC_B_FRZ_MRK = 28;
    localparam int PMMC_B_FRZ_UNM = 27;
    localparam int PMMC_B_IRQ_EN = 26;
    localparam int PMMC_B_FRZ_IRQ = 25;
    localparam int PMMC_B_TB_SEL_HI = 24;
    localparam int PMMC_B_TB_SEL_LO = 23;
    localparam int PMMC_B_TB_IRQ = 22;
    localparam int PMMC_B_THR_HI = 21;
    localparam int PMMC_B_THR_LO = 16;
    localparam int PMMC_B_C1_IRQ = 15;
    localparam int PMMC_B_CN_IRQ = 14;
    localparam int PMMC_B_CHAIN = 13;
    localparam int PMMC_B_SEL1_HI = 12;
    localparam int PMMC_B_SEL1_LO = 6;
    localparam int PMMC_B_SEL2_HI = 5;
    localparam int PMMC_B_SEL2_LO = 0;
    // time-base bit indices (big-endian 63,55,51,47 -> le 0,8,12,16)
    localparam int PMMC_TB_BIT0 = 0;
    localparam int PMMC_TB_BIT1 = 8;
    localparam int PMMC_TB_BIT2 = 12;
    localparam int PMMC_TB_BIT3 = 16;
    localparam int PMMC_NCNT = 4;
    typedef enum logic [2:0] {
        PMMC_IDLE = 3'b001,
        PMMC_HELD = 3'b010,
        PMMC_FIRED = 3'b100
    } pmmc_chain_t;
endpackage : pmmc_pkg

// [hw/pmmc_tb_watch.sv]
`timescale 1ns/1ps
// rising-edge detector on the selected time-base bit
module pmmc_tb_watch import pmmc_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // time base and selection
    input wire logic [63:0] time_base,
    input wire logic [1:0] sel,
    // result
    output logic rise_q
);
    logic [3:0] cand;
    logic [3:0] last_q;
    logic [3:0] last_d;
    logic rise_d;

    // keep all four candidates so a select change is never an edge
    always_comb begin
        cand = {time_base[PMMC_TB_BIT3], time_base[PMMC_TB_BIT2],
            time_base[PMMC_TB_BIT1], time_base[PMMC_TB_BIT0]};
        last_d = cand;
        rise_d = cand[sel] & ~last_q[sel];
    end

    // registers
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            last_q <= 4'h0;
            rise_q <= 1'b0;
        end else begin
            last_q <= last_d;
            rise_q <= rise_d;
        end
    end
endmodule : pmmc_tb_watch

// [hw/pmmc_gate.sv]
`timescale 1ns/1ps
// per-counter update enables from mode and chain state
module pmmc_gate import pmmc_pkg::*; (
    // inputs
    input wire logic base_ok,
    input wire logic one_ok,
    input wire logic upper_ok,
    // enables per counter, index 0 is counter one
    output logic [PMMC_NCNT-1:0] cnt_en
);
    genvar g;
    generate
        for (g = 0; g < PMMC_NCNT; g++) begin : g_en
            if (g == 0) begin : g_one
                assign cnt_en[g] = base_ok & one_ok;
            end else begin : g_up
                assign cnt_en[g] = base_ok & upper_ok;
            end
        end
    endgenerate
endmodule : pmmc_gate

// [hw/pmmc_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - 32-bit register, supervisor-only writes
// - register clears to zero at reset
// - reads never alter stored fields
// - global freeze stops all counters
// - freeze in supervisor when requested
// - freeze in user when requested
// - freeze while process mark set
// - freeze while process mark clear
// - irq enable cleared when interrupt taken
// - signal on enabled overflow or time-base rise
// - freeze-on-signal stops counter one, upper
// - select time-base bit 63/55/51/47
// - transition enable gates rise signalling
// - hardware never changes transition enable
// - six-bit latency threshold field
// - counter one overflow irq enable
// - upper counters overflow irq enable, overrides
// - chain holds upper counters until trigger
// - seven-bit counter one event select
// - six-bit counter two event select
// - control at special register 952
// - counter overflowed when top bit set
// - user mirror at 936 reads control
module pmmc_ctrl import pmmc_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // special-register move port
    input wire logic spr_wr,
    input wire logic spr_rd,
    input wire logic [9:0] spr_num,
    input wire logic [31:0] spr_wdata,
    output logic [31:0] spr_rdata_q,
    output logic spr_hit_q,
    output logic spr_priv_err_q,
    // core state
    input wire logic problem_state_bit,
    input wire logic process_mark_bit,
    input wire logic irq_taken,
    input wire logic [63:0] time_base,
    input wire logic [PMMC_NCNT-1:0] counter_msb,
    // to the counters and exception logic
    output logic [PMMC_NCNT-1:0] event_counter_en_q,
    output logic irq_signal_q,
    output logic [31:0] monitor_control_zero_q,
    output logic [5:0] threshold_q,
    output logic [6:0] counter_one_event_select_q,
    output logic [5:0] counter_two_event_select_q
);
    logic [31:0] ctl_q;
    logic [31:0] ctl_d;
    logic [31:0] rdata_d;
    logic hit_d;
    logic perr_d;
    logic tb_rise;
    logic sig_d;
    logic base_ok;
    logic one_ok;
    logic upper_ok;
    logic [PMMC_NCNT-1:0] en_c;
    pmmc_chain_t chain_q;
    pmmc_chain_t chain_d;
    logic ctl_sel;
    logic mir_sel;

    pmmc_tb_watch u_watch (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .time_base(time_base),
        .sel(ctl_q[PMMC_B_TB_SEL_HI:PMMC_B_TB_SEL_LO]),
        .rise_q(tb_rise)
    );

    assign ctl_sel = (spr_num == PMMC_SPR_CONTROL);
    assign mir_sel = (spr_num == PMMC_SPR_MIRROR);

    // register write and hardware clear
    always_comb begin
        ctl_d = ctl_q;
        if (spr_wr && ctl_sel && !problem_state_bit) begin
            ctl_d = spr_wdata;
        end
        // clear irq enable on take; bit 9 untouched
        if (irq_taken) begin
            ctl_d[PMMC_B_IRQ_EN] = 1'b0;
        end
    end

    // read port; no side effect
    always_comb begin
        rdata_d = 32'h0000_0000;
        hit_d = 1'b0;
        perr_d = 1'b0;
        if (spr_rd && (mir_sel || (ctl_sel && !problem_state_bit))) begin
            rdata_d = ctl_q;
            hit_d = 1'b1;
        end
        if ((spr_rd || spr_wr) && ctl_sel && problem_state_bit) begin
            perr_d = 1'b1;
        end
        if (spr_wr && mir_sel) begin
            perr_d = 1'b1;
        end
    end

    // interrupt signal condition
    always_comb begin
        // overflow or time-base rise, when enabled
        // overflow is the top bit; enables
        sig_d = ctl_q[PMMC_B_IRQ_EN] & (
            (ctl_q[PMMC_B_C1_IRQ] & counter_msb[0]) |
            (ctl_q[PMMC_B_CN_IRQ] & (|counter_msb[PMMC_NCNT-1:1])) |
            (ctl_q[PMMC_B_TB_IRQ] & tb_rise));
    end

    // chain trigger state
    always_comb begin
        chain_d = chain_q;
        unique case (chain_q)
            PMMC_IDLE: begin
                if (ctl_q[PMMC_B_CHAIN]) begin
                    // trigger already present: count at once
                    if (counter_msb[0] || irq_signal_q) begin
                        chain_d = PMMC_FIRED;
                    end else begin
                        chain_d = PMMC_HELD;
                    end
                end
            end
            PMMC_HELD: begin
                // release on counter one top bit or signal
                if (!ctl_q[PMMC_B_CHAIN]) begin
                    chain_d = PMMC_IDLE;
                end else if (counter_msb[0] || irq_signal_q) begin
                    chain_d = PMMC_FIRED;
                end
            end
            // once triggered, no re-arm until bit 18 is cleared
            PMMC_FIRED: begin
                if (!ctl_q[PMMC_B_CHAIN]) begin
                    chain_d = PMMC_IDLE;
                end
            end
            default: chain_d = PMMC_IDLE;
        endcase
    end

    // counting qualifiers
    always_comb begin
        base_ok = !ctl_q[PMMC_B_FREEZE]
            && !(ctl_q[PMMC_B_FRZ_SUP] && !problem_state_bit)
            && !(ctl_q[PMMC_B_FRZ_USR] && problem_state_bit)
            && !(ctl_q[PMMC_B_FRZ_MRK] && process_mark_bit)
            && !(ctl_q[PMMC_B_FRZ_UNM] && !process_mark_bit);
        // freeze on signal; upper enable overrides
        one_ok = !(ctl_q[PMMC_B_FRZ_IRQ] && irq_signal_q);
        upper_ok = (chain_q != PMMC_HELD)
            && (one_ok || ctl_q[PMMC_B_CN_IRQ]);
        if (ctl_q[PMMC_B_CHAIN] && chain_q == PMMC_IDLE
            && !counter_msb[0] && !irq_signal_q) begin
            upper_ok = 1'b0;
        end
    end

    pmmc_gate u_gate (
        .base_ok(base_ok),
        .one_ok(one_ok),
        .upper_ok(upper_ok),
        .cnt_en(en_c)
    );

    // state registers; cleared at reset, chain state to idle
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_q <= PMMC_RESET;
            chain_q <= PMMC_IDLE;
            spr_rdata_q <= 32'h0000_0000;
            spr_hit_q <= 1'b0;
            spr_priv_err_q <= 1'b0;
            irq_signal_q <= 1'b0;
            event_counter_en_q <= '0;
            monitor_control_zero_q <= PMMC_RESET;
            threshold_q <= 6'h00;
            counter_one_event_select_q <= 7'h00;
            counter_two_event_select_q <= 6'h00;
        end else begin
            ctl_q <= ctl_d;
            chain_q <= chain_d;
            spr_rdata_q <= rdata_d;
            spr_hit_q <= hit_d;
            spr_priv_err_q <= perr_d;
            irq_signal_q <= sig_d;
            event_counter_en_q <= en_c;
            monitor_control_zero_q <= ctl_d;
            threshold_q <= ctl_d[PMMC_B_THR_HI:PMMC_B_THR_LO];
            counter_one_event_select_q <=
                ctl_d[PMMC_B_SEL1_HI:PMMC_B_SEL1_LO];
            counter_two_event_select_q <=
                ctl_d[PMMC_B_SEL2_HI:PMMC_B_SEL2_LO];
        end
    end

    // assertions
    property p_freeze;
        @(posedge sys_clk) disable iff (!rst_b)
        ctl_q[PMMC_B_FREEZE] |=> (event_counter_en_q == '0);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("counters enabled under global freeze");

    property p_user_write;
        @(posedge sys_clk) disable iff (!rst_b)
        (spr_wr && problem_state_bit && !irq_taken)
            |=> $stable(ctl_q);
    endproperty
    a_user_write: assert property (p_user_write)
        else $error("user write changed control");

    property p_taken;
        @(posedge sys_clk) disable iff (!rst_b)
        irq_taken |=> !ctl_q[PMMC_B_IRQ_EN];
    endproperty
    a_taken: assert property (p_taken)
        else $error("irq enable not cleared");

    property p_tb_keep;
        @(posedge sys_clk) disable iff (!rst_b)
        !(spr_wr && ctl_sel && !problem_state_bit)
            |=> $stable(ctl_q[PMMC_B_TB_IRQ]);
    endproperty
    a_tb_keep: assert property (p_tb_keep)
        else $error("hardware changed transition enable");

    property p_noen;
        @(posedge sys_clk) disable iff (!rst_b)
        !ctl_q[PMMC_B_IRQ_EN] |=> !irq_signal_q;
    endproperty
    a_noen: assert property (p_noen)
        else $error("signal without global enable");

    property p_c1ov;
        @(posedge sys_clk) disable iff (!rst_b)
        (ctl_q[PMMC_B_IRQ_EN] && ctl_q[PMMC_B_C1_IRQ] && counter_msb[0])
            |=> irq_signal_q;
    endproperty
    a_c1ov: assert property (p_c1ov)
        else $error("counter one overflow not signalled");

    property p_sup;
        @(posedge sys_clk) disable iff (!rst_b)
        (ctl_q[PMMC_B_FRZ_SUP] && !problem_state_bit)
            |=> (event_counter_en_q == '0);
    endproperty
    a_sup: assert property (p_sup)
        else $error("counting in supervisor freeze");

    property p_mirror;
        @(posedge sys_clk) disable iff (!rst_b)
        (spr_rd && mir_sel) |=> (spr_hit_q && spr_rdata_q == $past(ctl_q));
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("mirror read mismatch");

    property p_user_frz;
        @(posedge sys_clk) disable iff (!rst_b)
        (ctl_q[PMMC_B_FRZ_USR] && problem_state_bit)
            |=> (event_counter_en_q == '0);
    endproperty
    a_user_frz: assert property (p_user_frz)
        else $error("counting in user freeze");

    property p_mark;
        @(posedge sys_clk) disable iff (!rst_b)
        (ctl_q[PMMC_B_FRZ_MRK] && process_mark_bit)
            |=> (event_counter_en_q == '0);
    endproperty
    a_mark: assert property (p_mark)
        else $error("counting while marked");

    property p_unmark;
        @(posedge sys_clk) disable iff (!rst_b)
        (ctl_q[PMMC_B_FRZ_UNM] && !process_mark_bit)
            |=> (event_counter_en_q == '0);
    endproperty
    a_unmark: assert property (p_unmark)
        else $error("counting while unmarked");

    property p_read_keep;
        @(posedge sys_clk) disable iff (!rst_b)
        (spr_rd && !spr_wr && !irq_taken) |=> $stable(ctl_q);
    endproperty
    a_read_keep: assert property (p_read_keep)
        else $error("read changed control");

    property p_chain_hold;
        @(posedge sys_clk) disable iff (!rst_b)
        (chain_q == PMMC_HELD)
            |=> (event_counter_en_q[PMMC_NCNT-1:1] == '0);
    endproperty
    a_chain_hold: assert property (p_chain_hold)
        else $error("upper counters enabled while held");

    c_sig: cover property (@(posedge sys_clk) disable iff (!rst_b)
        irq_signal_q);
    c_taken: cover property (@(posedge sys_clk) disable iff (!rst_b)
        irq_taken && ctl_q[PMMC_B_IRQ_EN]);
    c_held: cover property (@(posedge sys_clk) disable iff (!rst_b)
        chain_q == PMMC_HELD);
    c_fired: cover property (@(posedge sys_clk) disable iff (!rst_b)
        chain_q == PMMC_FIRED);
endmodule : pmmc_ctrl

// [test/pmmc_core.sv]
`timescale 1ns/1ps
// core side: move-to and move-from requests plus mode state
module pmmc_core import pmmc_pkg::*; (
    // clock
    input wire logic sys_clk,
    // move port
    output logic spr_wr,
    output logic spr_rd,
    output logic [9:0] spr_num,
    output logic [31:0] spr_wdata,
    // core state
    output logic problem_state_bit,
    output logic process_mark_bit,
    output logic [63:0] time_base
);
    // idle values at time zero
    initial begin
        spr_wr = 1'b0;
        spr_rd = 1'b0;
        spr_num = 10'h000;
        spr_wdata = 32'h0000_0000;
        problem_state_bit = 1'b0;
        process_mark_bit = 1'b0;
        time_base = 64'h0;
    end
    // mode bits and time base, changed between edges
    task automatic set_mode(input logic pr, input logic pm);
        problem_state_bit = pr;
        process_mark_bit = pm;
    endtask : set_mode
    task automatic set_tb(input logic [63:0] t);
        time_base = t;
    endtask : set_tb
    // one request held over its taking edge, then released
    // numbered move access
    task automatic req(input logic wr, input logic [9:0] num,
            input logic [31:0] data);
        @(negedge sys_clk);
        spr_wr = wr;
        spr_rd = ~wr;
        spr_num = num;
        spr_wdata = data;
        @(negedge sys_clk);
        spr_wr = 1'b0;
        spr_rd = 1'b0;
        spr_num = ~num; // released lines show no stale value
        spr_wdata = ~data;
    endtask : req
endmodule : pmmc_core

// [test/tb_top.sv]
`timescale 1ns/1ps
// self-checking bench for the monitor control register
module tb_top import pmmc_pkg::*; ();
    localparam logic [31:0] K_IEN = 32'h0400_0000;
    localparam logic [31:0] K_FRZ = 32'h0200_0000;
    localparam logic [31:0] K_TBI = 32'h0040_0000;
    localparam logic [31:0] K_C1I = 32'h0000_8000;
    localparam logic [31:0] K_CNI = 32'h0000_4000;
    localparam logic [31:0] K_CHN = 32'h0000_2000;
    localparam logic [31:0] K_IRQ = 32'h0640_e000;
    // stimulus and core-side nets
    logic sys_clk;
    logic rst_b;
    logic irq_taken;
    logic [3:0] counter_msb;
    logic spr_wr;
    logic spr_rd;
    logic [9:0] spr_num;
    logic [31:0] spr_wdata;
    logic problem_state_bit;
    logic process_mark_bit;
    logic [63:0] time_base;
    // design outputs
    logic [31:0] spr_rdata_q;
    logic spr_hit_q;
    logic spr_priv_err_q;
    logic [3:0] event_counter_en_q;
    logic irq_signal_q;
    logic [31:0] monitor_control_zero_q;
    logic [5:0] threshold_q;
    logic [6:0] counter_one_event_select_q;
    logic [5:0] counter_two_event_select_q;
    int err_count;
    int checks;
    logic [31:0] v;
    logic [31:0] w;

    // design and core model
    pmmc_ctrl pmmc_ctrl_inst (.sys_clk, .rst_b, .spr_wr, .spr_rd,
        .spr_num, .spr_wdata, .spr_rdata_q, .spr_hit_q, .spr_priv_err_q,
        .problem_state_bit, .process_mark_bit, .irq_taken, .time_base,
        .counter_msb, .event_counter_en_q, .irq_signal_q,
        .monitor_control_zero_q, .threshold_q,
        .counter_one_event_select_q, .counter_two_event_select_q);
    pmmc_core pmmc_core_inst (.sys_clk, .spr_wr, .spr_rd, .spr_num,
        .spr_wdata, .problem_state_bit, .process_mark_bit, .time_base);

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // expected counter enable from freeze bits and mode
    function automatic logic ok(input logic [31:0] c, input logic pr,
            input logic pm);
        return !(c[31] | (c[30] & !pr) | (c[29] & pr) | (c[28] & pm)
            | (c[27] & !pm));
    endfunction : ok

    // watched time-base bit per select: 63/55/51/47 counted from msb
    function automatic logic [63:0] tb_mask(input int s);
        int pick;
        pick = (s == 0) ? 63 : (s == 1) ? 55 : (s == 2) ? 51 : 47;
        return 64'h1 << (63 - pick);
    endfunction : tb_mask

    // value comparison
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // small drivers
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic wr(input logic [31:0] d);
        pmmc_core_inst.req(1'b1, PMMC_SPR_CONTROL, d);
    endtask : wr
    task automatic mode(input logic pr, input logic pm);
        @(negedge sys_clk);
        pmmc_core_inst.set_mode(pr, pm);
    endtask : mode
    task automatic take;
        @(negedge sys_clk);
        irq_taken = 1'b1;
        @(negedge sys_clk);
        irq_taken = 1'b0;
    endtask : take
    // bounded wait for the interrupt signal
    task automatic wait_sig;
        int n;
        n = 0;
        while (irq_signal_q !== 1'b1 && n < 4) begin
            tick(1);
            n++;
        end
        chk("irq_signal_q", 1, irq_signal_q);
        if (irq_signal_q !== 1'b1) begin
            close_out();
        end
    endtask : wait_sig

    // main sequence
    initial begin
        err_count = 0;
        checks = 0;
        rst_b = 1'b0;
        irq_taken = 1'b0;
        counter_msb = 4'h0;
        v = $urandom(32'h92285ac4);
        tick(5);
        rst_b = 1'b1;
        chk("reset", PMMC_RESET, monitor_control_zero_q);
        // random fields, modes and mirror reads
        for (int i = 0; i < 24; i++) begin
            v = $urandom() & ~K_IRQ;
            mode(1'b0, 1'b0);
            wr(v);
            chk("ctl", v, monitor_control_zero_q);
            chk("thr", v[21:16], threshold_q);
            chk("sel1", v[12:6], counter_one_event_select_q);
            chk("sel2", v[5:0], counter_two_event_select_q);
            w = $urandom();
            mode(w[0], w[1]);
            pmmc_core_inst.req(1'b0, PMMC_SPR_MIRROR, w);
            chk("mirror", v, spr_rdata_q);
            chk("hit", 1, spr_hit_q);
            chk("en", {4{ok(v, w[0], w[1])}}, event_counter_en_q);
            chk("keep", v, monitor_control_zero_q);
        end
        mode(1'b1, 1'b0);
        wr(~v);
        chk("uerr", 1, spr_priv_err_q);
        chk("ctl", v, monitor_control_zero_q);
        mode(1'b0, 1'b0);
        pmmc_core_inst.req(1'b1, PMMC_SPR_MIRROR, ~v);
        chk("merr", 1, spr_priv_err_q);
        pmmc_core_inst.req(1'b0, PMMC_SPR_CONTROL, 0);
        chk("sread", v, spr_rdata_q);
        pmmc_core_inst.req(1'b0, PMMC_SPR_CONTROL + 10'h1, 0);
        chk("nohit", 0, spr_hit_q);
        counter_msb = 4'h1;
        wr(K_IEN);
        tick(3);
        chk("nosig", 0, irq_signal_q);
        wr(K_IEN | K_TBI | K_C1I);
        wait_sig();
        tick(2);
        chk("en", 4'hf, event_counter_en_q);
        take();
        tick(1);
        chk("ctl", K_TBI | K_C1I, monitor_control_zero_q);
        // freeze on signal and its override
        wr(K_IEN | K_FRZ | K_C1I);
        wait_sig();
        tick(2);
        chk("en", 4'h0, event_counter_en_q);
        wr(K_IEN | K_FRZ | K_C1I | K_CNI);
        tick(3);
        chk("en", 4'he, event_counter_en_q);
        // chain hold until counter one overflows
        counter_msb = 4'h0;
        wr(K_CHN);
        tick(2);
        chk("en", 4'h1, event_counter_en_q);
        counter_msb = 4'h1;
        tick(2);
        chk("en", 4'hf, event_counter_en_q);
        counter_msb = 4'h0;
        tick(2);
        chk("en", 4'hf, event_counter_en_q);
        // only the selected time-base bit signals
        for (int s = 0; s < 4; s++) begin
            wr(K_IEN | K_TBI | (s << 23));
            pmmc_core_inst.set_tb(64'h1_1101 & ~tb_mask(s));
            tick(3);
            chk("tbsig", 0, irq_signal_q);
            pmmc_core_inst.set_tb(64'h1_1101);
            wait_sig();
            take();
            wr(32'h0);
            pmmc_core_inst.set_tb(64'h0);
        end
        wr(K_IEN);
        pmmc_core_inst.set_tb(64'h1);
        tick(3);
        chk("tboff", 0, irq_signal_q);
        close_out();
    end
endmodule : tb_top
